// [logic/aatd_consts.svh]
`ifndef AATD_CONSTS_SVH
`define AATD_CONSTS_SVH

// ***********************************
// device register map
// ***********************************
`define AATD_AW               11
`define AATD_OFS_RX_PD        11'h324
`define AATD_OFS_AUX_PD       11'h325
`define AATD_OFS_RES_UPPER    11'h327
`define AATD_OFS_RES_LOWER    11'h328
`define AATD_OFS_SRC_SEL      11'h359
`define AATD_OFS_PIN_CFG      11'h3FA
`define AATD_OFS_DAC_GAIN     11'h3FD
`define AATD_REG_RESET        8'h00

// ***********************************
// field positions and values
// ***********************************
`define AATD_RX_PD_ADC_EN_BIT  4
`define AATD_AUX_PD_TEMP_BIT   1
`define AATD_RX_PD_ADC_EN      8'h10
`define AATD_AUX_PD_TEMP_ON    8'h02
`define AATD_SRC_TEMP          8'h08
`define AATD_SRC_EXT           8'h04
`define AATD_PIN_CFG_TEST_DAC  8'hC9
`define AATD_DAC_GAIN_UNITY    8'h00

// ***********************************
// timing
// ***********************************
`define AATD_CLK_PERIOD_PS     5000
`define AATD_CONV_TIME_PS      1000000
`define AATD_CONV_CYCLES       (`AATD_CONV_TIME_PS / `AATD_CLK_PERIOD_PS)
`define AATD_SAR_BITS          8

// ***********************************
// host controller registers
// ***********************************
`define AATD_HOFS_CTRL         3'h0
`define AATD_HOFS_STATUS       3'h1
`define AATD_HOFS_RESULT       3'h2
`define AATD_HOFS_TEMP_LO      3'h3
`define AATD_HOFS_TEMP_HI      3'h4
`define AATD_HOFS_CORR_LO      3'h5
`define AATD_HOFS_CORR_HI      3'h6
`define AATD_CTRL_TEMP_SETUP   0
`define AATD_CTRL_DAC_ENABLE   1
`define AATD_CTRL_READBACK     2

// temperature in 1/256 degC: ((r*256 - 10802) * 1001) >>> 10
`define AATD_TEMP_OFFSET_Q8    10802
`define AATD_TEMP_SLOPE_NUM    1001
`define AATD_TEMP_SLOPE_SHIFT  10

`endif

// [logic/aatd_pkg.sv]
package aatd_pkg;

	// radio operating state seen by the converter block
	typedef enum logic [1:0] {
		AATD_RADIO_OFF = 2'b00,
		AATD_RADIO_ON  = 2'b01,
		AATD_RADIO_RX  = 2'b10,
		AATD_RADIO_TX  = 2'b11
	} aatd_radio_state_t;

	typedef enum logic [1:0] {
		AATD_RB_IDLE = 2'b00,
		AATD_RB_LOW  = 2'b01,
		AATD_RB_HIGH = 2'b10
	} aatd_rb_phase_t;

	typedef enum logic [1:0] {
		AATD_SRC_RSSI = 2'b00,
		AATD_SRC_EXTERNAL = 2'b01,
		AATD_SRC_TEMPERATURE = 2'b10
	} aatd_source_t;

	typedef enum logic {
		AATD_H_IDLE = 1'b0,
		AATD_H_RUN  = 1'b1
	} aatd_host_state_t;

	typedef struct packed {
		logic        rd;
		logic [10:0] addr;
		logic [7:0]  data;
	} aatd_step_t;

endpackage : aatd_pkg

// [logic/aatd_link_if.sv]
`timescale 1ns/10ps
// memory access link between host controller and converter block
interface aatd_link_if;
	logic [10:0] addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;

	modport dev (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata
	);

	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata
	);
endinterface : aatd_link_if

// [logic/aatd_device.sv]
`timescale 1ns/10ps
`include "aatd_consts.svh"

// How it works
// - converts selected source within about one microsecond
// - 8-bit result split over upper/lower registers
// - source from select register, rssi while receiving
// - converter on in receive, else rx power bit
// - upper read starts, lower bits1:0, upper bits7:2
// - aux power bit powers the temperature sensor
// - select value 0x08 routes temperature sensor
// - host converts result into degrees Celsius
// - second-order sigma-delta of filter onto pin zero
// - host writes pin config and gain to enable
module aatd_device #(
	parameter int unsigned CONV_CYCLES = `AATD_CONV_CYCLES,
	parameter int unsigned FILT_W      = 16
) (
	// clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_i,
	// register link
	aatd_link_if.dev                        link,
	// radio core
	input  aatd_pkg::aatd_radio_state_t     radio_state_i,
	input  wire logic signed [FILT_W-1:0]   filt_out_i,
	// analog levels as seen by the comparator
	input  wire logic [7:0]                 temp_level_i,
	input  wire logic [7:0]                 rssi_level_i,
	input  wire logic [7:0]                 ext_level_i,
	// status and pins
	output logic                            adc_enabled_o,
	output logic                            temp_sensor_on_o,
	output logic                            general_pin_zero_o,
	output logic                            general_pin_zero_oe_o
);
	import aatd_pkg::*;

	localparam int unsigned STEP_CYCLES = (CONV_CYCLES / `AATD_SAR_BITS > 0) ?
		CONV_CYCLES / `AATD_SAR_BITS : 1;
	localparam int unsigned CW = $clog2(STEP_CYCLES + 1);
	localparam int unsigned IW = FILT_W + 8;

	// ***********************************
	// register file
	// ***********************************
	logic [7:0]     rx_pd_q, rx_pd_d;
	logic [7:0]     aux_pd_q, aux_pd_d;
	logic [7:0]     src_sel_q, src_sel_d;
	logic [7:0]     pin_cfg_q, pin_cfg_d;
	logic [7:0]     dac_gain_q, dac_gain_d;
	logic [7:0]     rdata_q, rdata_d;
	logic [7:0]     hold_q, hold_d;
	aatd_rb_phase_t phase_q, phase_d;
	logic [7:0]     result_q;

	always_comb begin
		rx_pd_d    = rx_pd_q;
		aux_pd_d   = aux_pd_q;
		src_sel_d  = src_sel_q;
		pin_cfg_d  = pin_cfg_q;
		dac_gain_d = dac_gain_q;
		hold_d     = hold_q;
		phase_d    = phase_q;
		rdata_d    = 8'h00;
		if (link.wr) begin
			unique case (link.addr)
				`AATD_OFS_RX_PD:    rx_pd_d    = link.wdata;
				`AATD_OFS_AUX_PD:   aux_pd_d   = link.wdata;
				`AATD_OFS_SRC_SEL:  src_sel_d  = link.wdata;
				`AATD_OFS_PIN_CFG:  pin_cfg_d  = link.wdata;
				`AATD_OFS_DAC_GAIN: dac_gain_d = link.wdata;
				default: ;
			endcase
		end
		if (link.rd) begin
			unique case (link.addr)
				`AATD_OFS_RX_PD:    rdata_d = rx_pd_q;
				`AATD_OFS_AUX_PD:   rdata_d = aux_pd_q;
				`AATD_OFS_SRC_SEL:  rdata_d = src_sel_q;
				`AATD_OFS_PIN_CFG:  rdata_d = pin_cfg_q;
				`AATD_OFS_DAC_GAIN: rdata_d = dac_gain_q;
				`AATD_OFS_RES_UPPER: begin
					// final upper read gives bits 7:2
					if (phase_q == AATD_RB_HIGH) begin
						rdata_d = {2'b00, hold_q[7:2]};
						phase_d = AATD_RB_IDLE;
					end else begin
						// capture one sample for the sequence
						hold_d  = result_q;
						rdata_d = {2'b00, result_q[7:2]};
						phase_d = AATD_RB_LOW;
					end
				end
				`AATD_OFS_RES_LOWER: begin
					rdata_d = {6'b000000, hold_q[1:0]};
					if (phase_q == AATD_RB_LOW) begin
						phase_d = AATD_RB_HIGH;
					end
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_pd_q    <= `AATD_REG_RESET;
			aux_pd_q   <= `AATD_REG_RESET;
			src_sel_q  <= `AATD_REG_RESET;
			pin_cfg_q  <= `AATD_REG_RESET;
			dac_gain_q <= `AATD_REG_RESET;
			rdata_q    <= 8'h00;
			hold_q     <= 8'h00;
			phase_q    <= AATD_RB_IDLE;
		end else begin
			rx_pd_q    <= rx_pd_d;
			aux_pd_q   <= aux_pd_d;
			src_sel_q  <= src_sel_d;
			pin_cfg_q  <= pin_cfg_d;
			dac_gain_q <= dac_gain_d;
			rdata_q    <= rdata_d;
			hold_q     <= hold_d;
			phase_q    <= phase_d;
		end
	end

	assign link.rdata = rdata_q;

	// ***********************************
	// converter enable and source
	// ***********************************
	logic         adc_en;
	logic         temp_on;
	aatd_source_t src;
	logic [7:0]   level;

	// receive state or rx power bit enables
	assign adc_en = (radio_state_i == AATD_RADIO_RX) || rx_pd_q[`AATD_RX_PD_ADC_EN_BIT];
	// aux power bit powers the sensor
	assign temp_on = aux_pd_q[`AATD_AUX_PD_TEMP_BIT];

	always_comb begin
		// receive state forces the rssi level
		if (radio_state_i == AATD_RADIO_RX) begin
			src = AATD_SRC_RSSI;
		end else if (src_sel_q == `AATD_SRC_TEMP) begin
			src = AATD_SRC_TEMPERATURE;
		end else if (src_sel_q == `AATD_SRC_EXT) begin
			src = AATD_SRC_EXTERNAL;
		end else begin
			src = AATD_SRC_RSSI;
		end
		unique case (src)
			AATD_SRC_TEMPERATURE: level = temp_on ? temp_level_i : 8'h00;
			AATD_SRC_EXTERNAL:    level = ext_level_i;
			default:              level = rssi_level_i;
		endcase
	end

	// ***********************************
	// successive approximation
	// ***********************************
	logic [CW-1:0] cnt_q, cnt_d;
	logic [2:0]    bit_q, bit_d;
	logic [7:0]    trial_q, trial_d;
	logic [7:0]    samp_q, samp_d;
	logic [7:0]    result_d;
	logic [7:0]    decided;

	always_comb begin
		cnt_d    = cnt_q;
		bit_d    = bit_q;
		trial_d  = trial_q;
		samp_d   = samp_q;
		result_d = result_q;
		decided  = trial_q;
		if (trial_q > samp_q) begin
			decided[bit_q] = 1'b0;
		end
		if (!adc_en) begin
			cnt_d   = '0;
			bit_d   = 3'h7;
			trial_d = 8'h80;
			samp_d  = level;
		// eight steps spread over the conversion time
		end else if (cnt_q != CW'(STEP_CYCLES - 1)) begin
			cnt_d = cnt_q + CW'(1);
		end else begin
			cnt_d = '0;
			if (bit_q == 3'h0) begin
				result_d = decided;
				bit_d    = 3'h7;
				trial_d  = 8'h80;
				samp_d   = level;
			end else begin
				bit_d                = bit_q - 3'h1;
				trial_d              = decided;
				trial_d[bit_q - 3'h1] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_q    <= '0;
			bit_q    <= 3'h7;
			trial_q  <= 8'h80;
			samp_q   <= 8'h00;
			result_q <= 8'h00;
		end else begin
			cnt_q    <= cnt_d;
			bit_q    <= bit_d;
			trial_q  <= trial_d;
			samp_q   <= samp_d;
			result_q <= result_d;
		end
	end

	assign adc_enabled_o    = adc_en;
	assign temp_sensor_on_o = temp_on;

	// ***********************************
	// test dac modulator
	// ***********************************
	logic                 dac_en;
	logic signed [IW-1:0] x_ext;
	logic signed [IW-1:0] fb;
	logic signed [IW-1:0] int1_q, int1_d;
	logic signed [IW-1:0] int2_q, int2_d;
	logic                 pin_q, pin_d;

	localparam logic signed [IW-1:0] FULL_SCALE = IW'(1) <<< (FILT_W - 1);

	assign dac_en = (pin_cfg_q == `AATD_PIN_CFG_TEST_DAC);
	// gain register attenuates by a power of two, zero is unity
	assign x_ext  = IW'(filt_out_i) >>> dac_gain_q[3:0];
	assign fb     = int2_q[IW-1] ? -FULL_SCALE : FULL_SCALE;

	always_comb begin
		int1_d = int1_q + x_ext - fb;
		// second stage takes the fresh first stage so the noise shaping is a clean double zero
		int2_d = int2_q + int1_d - fb;
		pin_d  = ~int2_d[IW-1];
		if (!dac_en) begin
			int1_d = '0;
			int2_d = '0;
			pin_d  = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			int1_q <= '0;
			int2_q <= '0;
			pin_q  <= 1'b0;
		end else begin
			int1_q <= int1_d;
			int2_q <= int2_d;
			pin_q  <= pin_d;
		end
	end

	assign general_pin_zero_o    = pin_q;
	assign general_pin_zero_oe_o = dac_en;

endmodule : aatd_device

// [logic/aatd_host.sv]
`timescale 1ns/10ps
`include "aatd_consts.svh"

module aatd_host (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// user register port
	input  wire logic [2:0]  usr_addr_i,
	input  wire logic [7:0]  usr_wdata_i,
	input  wire logic        usr_wr_i,
	input  wire logic        usr_rd_i,
	output logic      [7:0]  usr_rdata_o,
	output logic             busy_o,
	// link to converter block
	aatd_link_if.host        link
);
	import aatd_pkg::*;

	function automatic aatd_step_t step_of(input logic [2:0] idx);
		unique case (idx)
			3'h0: step_of = '{1'b0, `AATD_OFS_RX_PD, `AATD_RX_PD_ADC_EN};
			3'h1: step_of = '{1'b0, `AATD_OFS_AUX_PD, `AATD_AUX_PD_TEMP_ON};
			3'h2: step_of = '{1'b0, `AATD_OFS_SRC_SEL, `AATD_SRC_TEMP};
			3'h3: step_of = '{1'b0, `AATD_OFS_PIN_CFG, `AATD_PIN_CFG_TEST_DAC};
			3'h4: step_of = '{1'b0, `AATD_OFS_DAC_GAIN, `AATD_DAC_GAIN_UNITY};
			3'h5: step_of = '{1'b1, `AATD_OFS_RES_UPPER, 8'h00};
			3'h6: step_of = '{1'b1, `AATD_OFS_RES_LOWER, 8'h00};
			default: step_of = '{1'b1, `AATD_OFS_RES_UPPER, 8'h00};
		endcase
	endfunction : step_of

	// ***********************************
	// sequencer and link drive
	// ***********************************
	aatd_host_state_t st_q, st_d;
	logic [2:0]       idx_q, idx_d, last_q, last_d;
	aatd_step_t       lk_q, lk_d;
	logic             lkwr_q, lkwr_d;
	logic [1:0]       cap1_q, cap1_d, cap2_q;
	logic [7:0]       res_q, res_d;
	logic             done_q, done_d;
	logic signed [15:0] corr_q, corr_d, temp_q, temp_d;
	logic [7:0]       urd_q, urd_d;
	logic signed [31:0] diff, prod;
	logic             go;

	assign busy_o = (st_q == AATD_H_RUN) || (cap1_q != 2'b00) || (cap2_q != 2'b00);
	assign go     = usr_wr_i && (usr_addr_i == `AATD_HOFS_CTRL) && !busy_o;

	always_comb begin
		st_d   = st_q;
		idx_d  = idx_q;
		last_d = last_q;
		lk_d   = lk_q;
		lkwr_d = 1'b0;
		lk_d.rd = 1'b0;
		cap1_d = 2'b00;
		res_d  = res_q;
		done_d = done_q;
		corr_d = corr_q;
		if (go) begin
			done_d = 1'b0;
			st_d   = AATD_H_RUN;
			if (usr_wdata_i[`AATD_CTRL_TEMP_SETUP]) begin
				idx_d  = 3'h0;
				last_d = 3'h2;
			end else if (usr_wdata_i[`AATD_CTRL_DAC_ENABLE]) begin
				idx_d  = 3'h3;
				last_d = 3'h4;
			end else if (usr_wdata_i[`AATD_CTRL_READBACK]) begin
				idx_d  = 3'h5;
				last_d = 3'h7;
			end else begin
				st_d = AATD_H_IDLE;
			end
		end else if (st_q == AATD_H_RUN) begin
			lk_d   = step_of(idx_q);
			lkwr_d = !lk_d.rd;
			cap1_d = (idx_q == 3'h6) ? 2'b01 : (idx_q == 3'h7) ? 2'b10 : 2'b00;
			idx_d  = idx_q + 3'h1;
			if (idx_q == last_q) begin
				st_d   = AATD_H_IDLE;
				done_d = (last_q != 3'h7);
			end
		end
		if (cap2_q == 2'b01) begin
			res_d[1:0] = link.rdata[1:0];
		end
		if (cap2_q == 2'b10) begin
			res_d[7:2] = link.rdata[5:0];
			done_d     = 1'b1;
		end
		if (usr_wr_i && usr_addr_i == `AATD_HOFS_CORR_LO) begin
			corr_d[7:0] = usr_wdata_i;
		end
		if (usr_wr_i && usr_addr_i == `AATD_HOFS_CORR_HI) begin
			corr_d[15:8] = usr_wdata_i;
		end
	end

	// (r - 42.197)/1.023 plus correction, in 1/256 degC
	assign diff   = $signed({16'h0000, res_q, 8'h00}) - 32'sd`AATD_TEMP_OFFSET_Q8;
	assign prod   = (diff * 32'sd`AATD_TEMP_SLOPE_NUM) >>> `AATD_TEMP_SLOPE_SHIFT;
	assign temp_d = 16'(prod) + corr_q;

	always_comb begin
		unique case (usr_addr_i)
			`AATD_HOFS_STATUS:  urd_d = {6'b000000, done_q, busy_o};
			`AATD_HOFS_RESULT:  urd_d = res_q;
			`AATD_HOFS_TEMP_LO: urd_d = temp_q[7:0];
			`AATD_HOFS_TEMP_HI: urd_d = temp_q[15:8];
			`AATD_HOFS_CORR_LO: urd_d = corr_q[7:0];
			`AATD_HOFS_CORR_HI: urd_d = corr_q[15:8];
			default:            urd_d = 8'h00;
		endcase
		if (!usr_rd_i) begin
			urd_d = 8'h00;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_q   <= AATD_H_IDLE;
			idx_q  <= 3'h0;
			last_q <= 3'h0;
			lk_q   <= '0;
			lkwr_q <= 1'b0;
			cap1_q <= 2'b00;
			cap2_q <= 2'b00;
			res_q  <= 8'h00;
			done_q <= 1'b0;
			corr_q <= 16'sh0000;
			temp_q <= 16'sh0000;
			urd_q  <= 8'h00;
		end else begin
			st_q   <= st_d;
			idx_q  <= idx_d;
			last_q <= last_d;
			lk_q   <= lk_d;
			lkwr_q <= lkwr_d;
			cap1_q <= cap1_d;
			cap2_q <= cap1_q;
			res_q  <= res_d;
			done_q <= done_d;
			corr_q <= corr_d;
			temp_q <= temp_d;
			urd_q  <= urd_d;
		end
	end

	assign link.addr   = lk_q.addr;
	assign link.wdata  = lk_q.data;
	assign link.wr     = lkwr_q;
	assign link.rd     = lk_q.rd;
	assign usr_rdata_o = urd_q;

endmodule : aatd_host

// [bench/aatd_monitor.sv]
`timescale 1ns/10ps
`include "aatd_consts.svh"

module aatd_monitor (
	// clock and reset
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	// link signals
	input wire logic [10:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// ***********************************
	// link protocol
	// ***********************************
	property p_no_overlap;
		!(wr && rd);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("read and write strobes together");

	property p_rdata_idle;
		!rd |=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read reply");

	property p_upper_fmt;
		rd && addr == `AATD_OFS_RES_UPPER |=> rdata[7:6] == 2'b00;
	endproperty
	a_upper_fmt: assert property (p_upper_fmt)
		else $error("upper reply carries more than six bits");

	property p_lower_fmt;
		rd && addr == `AATD_OFS_RES_LOWER |=> rdata[7:2] == 6'h00;
	endproperty
	a_lower_fmt: assert property (p_lower_fmt)
		else $error("lower reply carries more than two bits");

	// ***********************************
	// host sequences
	// ***********************************
	property p_rb_order;
		rd && addr == `AATD_OFS_RES_UPPER && !$past(rd) |=>
			rd && addr == `AATD_OFS_RES_LOWER ##1 rd && addr == `AATD_OFS_RES_UPPER;
	endproperty
	a_rb_order: assert property (p_rb_order)
		else $error("readback reads out of order");

	property p_rb_hold;
		rd && addr == `AATD_OFS_RES_UPPER ##1 rd && addr == `AATD_OFS_RES_LOWER
			##1 rd && addr == `AATD_OFS_RES_UPPER |=> rdata == $past(rdata, 2);
	endproperty
	a_rb_hold: assert property (p_rb_hold)
		else $error("upper bits changed within one readback");

	property p_temp_seq;
		wr && addr == `AATD_OFS_RX_PD |-> wdata == `AATD_RX_PD_ADC_EN
			##1 wr && addr == `AATD_OFS_AUX_PD && wdata == `AATD_AUX_PD_TEMP_ON
			##1 wr && addr == `AATD_OFS_SRC_SEL && wdata == `AATD_SRC_TEMP;
	endproperty
	a_temp_seq: assert property (p_temp_seq)
		else $error("temperature setup writes wrong");

	property p_dac_seq;
		wr && addr == `AATD_OFS_PIN_CFG |-> wdata == `AATD_PIN_CFG_TEST_DAC
			##1 wr && addr == `AATD_OFS_DAC_GAIN && wdata == `AATD_DAC_GAIN_UNITY;
	endproperty
	a_dac_seq: assert property (p_dac_seq)
		else $error("test output setup writes wrong");
endmodule : aatd_monitor

// [bench/aatd_tb_top.sv]
`timescale 1ns/10ps
`include "aatd_consts.svh"

module aatd_tb_top;
	import aatd_pkg::*;
	localparam int unsigned CONV = 16;
	localparam logic [7:0] TEMP_LVL = 8'h3C;
	localparam logic [7:0] RSSI_LVL = 8'hA5;
	localparam logic [15:0] CORR = 16'h0180;

	logic               core_clk_i, rst_i, usr_wr_i, usr_rd_i, busy_o;
	logic [2:0]         usr_addr_i;
	logic [7:0]         usr_wdata_i, usr_rdata_o, temp_level_i, rssi_level_i, ext_level_i, r;
	aatd_radio_state_t  radio_state_i;
	logic signed [15:0] filt_out_i;
	logic               adc_enabled_o, temp_sensor_on_o, general_pin_zero_o, general_pin_zero_oe_o;
	int                 num_errors, n_checks, cycles, t, ones;

	aatd_link_if link ();

	aatd_host aatd_host_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .usr_addr_i(usr_addr_i),
		.usr_wdata_i(usr_wdata_i), .usr_wr_i(usr_wr_i), .usr_rd_i(usr_rd_i),
		.usr_rdata_o(usr_rdata_o), .busy_o(busy_o), .link(link));

	aatd_device #(.CONV_CYCLES(CONV)) aatd_device_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.link(link), .radio_state_i(radio_state_i), .filt_out_i(filt_out_i),
		.temp_level_i(temp_level_i), .rssi_level_i(rssi_level_i), .ext_level_i(ext_level_i),
		.adc_enabled_o(adc_enabled_o), .temp_sensor_on_o(temp_sensor_on_o),
		.general_pin_zero_o(general_pin_zero_o), .general_pin_zero_oe_o(general_pin_zero_oe_o));

	aatd_monitor aatd_monitor_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

	// ***********************************
	// helpers
	// ***********************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic op(input logic w, input logic rq, input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		usr_wr_i <= w;
		usr_rd_i <= rq;
		usr_addr_i <= a;
		usr_wdata_i <= d;
	endtask : op

	task automatic idle();
		@(posedge core_clk_i);
		usr_wr_i <= 1'b0;
		usr_rd_i <= 1'b0;
	endtask : idle

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		op(1'b1, 1'b0, a, d);
		idle();
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		op(1'b0, 1'b1, a, 8'h00);
		idle();
		#1;
		d = usr_rdata_o;
	endtask : rd_reg

	task automatic wait_idle();
		int n;
		n = 0;
		@(posedge core_clk_i);
		#1;
		while (busy_o !== 1'b0 && n < 200) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		chk({7'h00, busy_o}, 8'h00);
	endtask : wait_idle

	task automatic readback(output logic [7:0] d);
		wr_reg(3'h0, 8'h04);
		wait_idle();
		rd_reg(3'h2, d);
	endtask : readback

	// ***********************************
	// scenarios
	// ***********************************
	task automatic s_temp();
		chk({7'h00, adc_enabled_o}, 8'h00);
		chk({7'h00, temp_sensor_on_o}, 8'h00);
		wr_reg(3'h5, CORR[7:0]);
		wr_reg(3'h6, CORR[15:8]);
		wr_reg(3'h0, 8'h01);
		wait_idle();
		chk({7'h00, adc_enabled_o}, 8'h01);
		chk({7'h00, temp_sensor_on_o}, 8'h01);
		repeat (3 * CONV + 10) @(posedge core_clk_i);
		readback(r);
		chk(r, TEMP_LVL);
		repeat (3) @(posedge core_clk_i);
		t = ((int'(TEMP_LVL) * 256 - `AATD_TEMP_OFFSET_Q8) * `AATD_TEMP_SLOPE_NUM)
			>>> `AATD_TEMP_SLOPE_SHIFT;
		t = t + int'(CORR);
		rd_reg(3'h3, r);
		chk(r, t[7:0]);
		rd_reg(3'h4, r);
		chk(r, t[15:8]);
		rd_reg(3'h1, r);
		chk(r, 8'h02);
	endtask : s_temp

	task automatic s_rx_override();
		@(posedge core_clk_i);
		radio_state_i <= AATD_RADIO_RX;
		repeat (3 * CONV + 10) @(posedge core_clk_i);
		readback(r);
		chk(r, RSSI_LVL);
		chk({7'h00, adc_enabled_o}, 8'h01);
	endtask : s_rx_override

	task automatic s_refuse();
		op(1'b1, 1'b0, 3'h0, 8'h04);
		op(1'b1, 1'b0, 3'h0, 8'h02);
		idle();
		wait_idle();
		chk({7'h00, general_pin_zero_oe_o}, 8'h00);
		rd_reg(3'h7, r);
		chk(r, 8'h00);
	endtask : s_refuse

	task automatic count_ones(input logic signed [15:0] v, output int k);
		@(posedge core_clk_i);
		filt_out_i <= v;
		repeat (32) @(posedge core_clk_i);
		k = 0;
		repeat (64) begin
			@(posedge core_clk_i);
			#1;
			k += int'(general_pin_zero_o);
		end
	endtask : count_ones

	task automatic s_test_dac();
		wr_reg(3'h0, 8'h02);
		wait_idle();
		chk({7'h00, general_pin_zero_oe_o}, 8'h01);
		count_ones(16'sh6000, ones);
		chk({7'h00, ones > 40}, 8'h01);
		count_ones(-16'sh6000, ones);
		chk({7'h00, ones < 24}, 8'h01);
	endtask : s_test_dac

	// ***********************************
	// run control
	// ***********************************
	task automatic report_and_stop();
		$display("checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		{num_errors, n_checks, cycles} = '0;
		rst_i = 1'b1;
		{usr_wr_i, usr_rd_i, usr_addr_i, usr_wdata_i} = '0;
		radio_state_i = AATD_RADIO_OFF;
		filt_out_i = 16'sh0000;
		temp_level_i = TEMP_LVL;
		rssi_level_i = RSSI_LVL;
		ext_level_i = 8'h5A;
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		s_temp();
		s_rx_override();
		s_refuse();
		s_test_dac();
		report_and_stop();
	end
endmodule : aatd_tb_top
